// >>> design/ulf_line_core.sv
// serial line format, line status and interrupt identification core
// assumes bus strobes and serial input are synchronous to clk_i
`timescale 1ns/1ps
`default_nettype none
module ulf_line_core import ulf_pkg::*; (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    input wire logic cs_i,
    input wire logic rd_i,
    input wire logic wr_i,
    input wire logic [2:0] addr_i,
    input wire logic [7:0] wdata_i,
    output logic [7:0] rdata_o,
    output logic intr_o,
    input wire logic serial_in_i,
    output logic serial_out_o,
    input wire logic [3:0] modem_n_i
);

    ////////////////////////////////////////////////////////////////////////
    // helpers
    function automatic logic [7:0] len_mask(input logic [7:0] f);
        len_mask = 8'hFF >> (2'h3 - f[1:0]);
    endfunction

    function automatic logic par_of(input logic [7:0] d, input logic [7:0] f);
        logic x;
        x = ^(d & len_mask(f));
        if (f[FMT_STICK]) begin
            par_of = ~f[FMT_EVEN];
        end else begin
            par_of = f[FMT_EVEN] ? x : ~x;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // register bus decode
    logic [7:0] fmt_q, ien_q, scr_q, hold_q, tsr_q, rsh_q, rxbuf_q, rdata_q, lfl;
    logic [15:0] div_q, bcnt_q;
    logic tick_q, reload_q, intr_q, ser_out_q;
    logic dla, wr, rd, hold_wr, ien_wr, div_wr, rxbuf_rd, lfl_rd, iid_rd, mfl_rd;
    logic [2:0] iid_code, last_idx;

    assign dla = fmt_q[FMT_DIV];
    assign wr = cs_i & wr_i;
    assign rd = cs_i & rd_i;
    assign hold_wr = wr & (addr_i == A_DATA) & ~dla;
    assign ien_wr = wr & (addr_i == A_IEN) & ~dla;
    assign div_wr = wr & dla & ((addr_i == A_DATA) | (addr_i == A_IEN));
    assign rxbuf_rd = rd & (addr_i == A_DATA) & ~dla;
    assign lfl_rd = rd & (addr_i == A_LFL);
    assign iid_rd = rd & (addr_i == A_IID);
    assign mfl_rd = rd & (addr_i == A_MFL);
    assign last_idx = 3'h4 + {1'b0, fmt_q[1:0]};

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            fmt_q <= FMT_RST;
            ien_q <= IEN_RST;
            div_q <= DIV_RST;
            scr_q <= 8'h00;
        end else if (ce_i && wr) begin
            if (addr_i == A_DATA && dla) begin
                div_q[7:0] <= wdata_i;
            end else if (addr_i == A_IEN && dla) begin
                div_q[15:8] <= wdata_i;
            end else if (addr_i == A_IEN) begin
                ien_q <= {4'h0, wdata_i[3:0]};
            end else if (addr_i == A_FMT) begin
                fmt_q <= wdata_i;
            end else if (addr_i == A_SCR) begin
                scr_q <= wdata_i;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // 16x tick from divisor, reloaded on any divisor write
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            bcnt_q <= DIV_RST;
            tick_q <= 1'b0;
            reload_q <= 1'b0;
        end else if (ce_i) begin
            reload_q <= div_wr;
            if (reload_q) begin
                bcnt_q <= div_q;
                tick_q <= 1'b0;
            end else if (bcnt_q <= 16'h0001) begin
                bcnt_q <= div_q;
                tick_q <= 1'b1;
            end else begin
                bcnt_q <= bcnt_q - 16'h0001;
                tick_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // receiver
    ulf_state_t rx_st_q;
    logic [3:0] rx_cnt_q;
    logic [2:0] rx_idx_q;
    logic rx_allz_q, rx_par_q, rx_smp, rx_end, brk_set, rx_push, par_set, frm_set;
    logic [7:0] rx_data;

    assign rx_smp = tick_q & (rx_cnt_q == TICK_LAST);
    assign rx_data = rsh_q >> (2'h3 - fmt_q[1:0]);
    assign rx_end = rx_smp & (rx_st_q == S_STOP);
    assign brk_set = rx_end & rx_allz_q & ~serial_in_i;
    assign rx_push = rx_end & ~brk_set;
    assign par_set = rx_push & fmt_q[FMT_PAR_EN] & (rx_par_q != par_of(rx_data, fmt_q));
    assign frm_set = rx_push & ~serial_in_i;

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rx_st_q <= S_IDLE;
            rx_cnt_q <= 4'h0;
            rx_idx_q <= 3'h0;
            rx_allz_q <= 1'b0;
            rx_par_q <= 1'b0;
            rsh_q <= 8'h00;
        end else if (ce_i) begin
            case (rx_st_q)
                S_IDLE: begin
                    if (!serial_in_i) begin
                        rx_st_q <= S_START;
                        rx_cnt_q <= 4'h0;
                    end
                end
                S_START: begin
                    if (tick_q) begin
                        rx_cnt_q <= rx_cnt_q + 4'h1;
                        if (rx_cnt_q == TICK_MID) begin
                            rx_cnt_q <= 4'h0;
                            rx_idx_q <= 3'h0;
                            rx_allz_q <= 1'b1;
                            rx_st_q <= serial_in_i ? S_IDLE : S_DATA;
                        end
                    end
                end
                S_DATA, S_PAR, S_STOP: begin
                    if (tick_q) begin
                        rx_cnt_q <= rx_cnt_q + 4'h1;
                    end
                    if (rx_smp) begin
                        rx_allz_q <= rx_allz_q & ~serial_in_i;
                        if (rx_st_q == S_DATA) begin
                            rsh_q <= {serial_in_i, rsh_q[7:1]};
                            rx_idx_q <= rx_idx_q + 3'h1;
                            if (rx_idx_q == last_idx) begin
                                rx_st_q <= fmt_q[FMT_PAR_EN] ? S_PAR : S_STOP;
                            end
                        end else if (rx_st_q == S_PAR) begin
                            rx_par_q <= serial_in_i;
                            rx_st_q <= S_STOP;
                        end else begin
                            rx_st_q <= brk_set ? S_BRK : S_IDLE;
                        end
                    end
                end
                S_BRK: begin
                    if (serial_in_i) begin
                        rx_st_q <= S_IDLE;
                    end
                end
                default: begin
                    rx_st_q <= S_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // two-entry receive buffer ahead of receive_buffer
    logic [7:0] fifo_q [FIFO_DEPTH];
    logic wp_q, rp_q, rdy_q, oe_q, par_err_q, frm_err_q, brk_q, f_full, push_ok, pop;
    logic [1:0] fcnt_q;

    assign f_full = (fcnt_q == FIFO_FULL);
    assign push_ok = rx_push & ~f_full;
    assign pop = (fcnt_q != 2'h0) & ~rdy_q;

    always_ff @(posedge clk_i) begin
        if (ce_i && push_ok) begin
            fifo_q[wp_q] <= rx_data;
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            wp_q <= 1'b0;
            rp_q <= 1'b0;
            fcnt_q <= 2'h0;
        end else if (ce_i) begin
            if (push_ok) begin
                wp_q <= ~wp_q;
            end
            if (pop) begin
                rp_q <= ~rp_q;
            end
            case ({push_ok, pop})
                2'b10: fcnt_q <= fcnt_q + 2'h1;
                2'b01: fcnt_q <= fcnt_q - 2'h1;
                default: fcnt_q <= fcnt_q;
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rxbuf_q <= 8'h00;
            rdy_q <= 1'b0;
            oe_q <= 1'b0;
            par_err_q <= 1'b0;
            frm_err_q <= 1'b0;
            brk_q <= 1'b0;
        end else if (ce_i) begin
            if (pop) begin
                rxbuf_q <= fifo_q[rp_q];
            end
            rdy_q <= pop | (rdy_q & ~rxbuf_rd);
            oe_q <= (rx_push & f_full) | (oe_q & ~lfl_rd);
            par_err_q <= par_set | (par_err_q & ~lfl_rd);
            frm_err_q <= frm_set | (frm_err_q & ~lfl_rd);
            brk_q <= brk_set | (brk_q & ~lfl_rd);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // transmitter
    ulf_state_t tx_st_q;
    logic [5:0] tx_cnt_q, stop_last;
    logic [2:0] tx_idx_q;
    logic tx_par_q, hold_empty_q, tx_idle, tx_load, tx_bit_end, tx_line;

    assign tx_idle = (tx_st_q == S_IDLE);
    assign tx_load = tx_idle & ~hold_empty_q;
    assign stop_last = !fmt_q[FMT_STOPS] ? STOP1_LAST :
        ((fmt_q[1:0] == 2'h0) ? STOP15_LAST : STOP2_LAST);
    assign tx_bit_end = tick_q & ((tx_st_q == S_STOP) ? (tx_cnt_q == stop_last) :
        (tx_cnt_q[3:0] == TICK_LAST));

    always_comb begin
        case (tx_st_q)
            S_START: tx_line = 1'b0;
            S_DATA: tx_line = tsr_q[0];
            S_PAR: tx_line = tx_par_q;
            default: tx_line = 1'b1;
        endcase
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            hold_q <= 8'h00;
            hold_empty_q <= 1'b1;
        end else if (ce_i) begin
            if (hold_wr) begin
                hold_q <= wdata_i;
                hold_empty_q <= 1'b0;
            end else if (tx_load) begin
                hold_empty_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            tx_st_q <= S_IDLE;
            tx_cnt_q <= 6'h00;
            tx_idx_q <= 3'h0;
            tx_par_q <= 1'b0;
            tsr_q <= 8'h00;
        end else if (ce_i) begin
            if (tx_load) begin
                tsr_q <= hold_q;
                tx_par_q <= par_of(hold_q, fmt_q);
                tx_st_q <= S_START;
                tx_cnt_q <= 6'h00;
            end else if (!tx_idle && tick_q) begin
                tx_cnt_q <= tx_bit_end ? 6'h00 : tx_cnt_q + 6'h01;
                if (tx_bit_end) begin
                    case (tx_st_q)
                        S_START: begin
                            tx_st_q <= S_DATA;
                            tx_idx_q <= 3'h0;
                        end
                        S_DATA: begin
                            tsr_q <= tsr_q >> 1;
                            tx_idx_q <= tx_idx_q + 3'h1;
                            if (tx_idx_q == last_idx) begin
                                tx_st_q <= fmt_q[FMT_PAR_EN] ? S_PAR : S_STOP;
                            end
                        end
                        S_PAR: tx_st_q <= S_STOP;
                        default: tx_st_q <= S_IDLE;
                    endcase
                end
            end
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ser_out_q <= 1'b1;
        end else if (ce_i) begin
            ser_out_q <= fmt_q[FMT_BREAK] ? 1'b0 : tx_line;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // modem line change flags
    logic [3:0] mprev_q, mdelta_q, mchg, mset;

    assign mchg = modem_n_i ^ mprev_q;
    assign mset = {mchg[3], modem_n_i[2] & ~mprev_q[2], mchg[1], mchg[0]};

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            mprev_q <= MDM_RST;
            mdelta_q <= 4'h0;
        end else if (ce_i) begin
            mprev_q <= modem_n_i;
            mdelta_q <= mset | (mdelta_q & {4{~mfl_rd}});
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt priority and identification
    logic hold_ip_q, int_line, int_rxd, int_hold, int_mdm, int_any, hold_ip_set;

    assign int_line = ien_q[IEN_LINE] & (oe_q | par_err_q | frm_err_q | brk_q);
    assign int_rxd = ien_q[IEN_RXD] & rdy_q;
    assign int_hold = ien_q[IEN_HOLD] & hold_ip_q;
    assign int_mdm = ien_q[IEN_MDM] & (mdelta_q != 4'h0);
    assign int_any = int_line | int_rxd | int_hold | int_mdm;
    assign hold_ip_set = tx_load | (ien_wr & wdata_i[IEN_HOLD] & ~ien_q[IEN_HOLD] & hold_empty_q);

    always_comb begin
        if (int_line) begin
            iid_code = ID_LINE;
        end else if (int_rxd) begin
            iid_code = ID_RXD;
        end else if (int_hold) begin
            iid_code = ID_HOLD;
        end else if (int_mdm) begin
            iid_code = ID_MDM;
        end else begin
            iid_code = ID_NONE;
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            hold_ip_q <= 1'b0;
            intr_q <= 1'b0;
        end else if (ce_i) begin
            hold_ip_q <= ~hold_wr & (hold_ip_set |
                (hold_ip_q & ~(iid_rd & (iid_code == ID_HOLD))));
            intr_q <= int_any;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read path
    logic [7:0] rmux;

    assign lfl = {1'b0, hold_empty_q & tx_idle, hold_empty_q, brk_q, frm_err_q, par_err_q, oe_q, rdy_q};

    always_comb begin
        if (addr_i == A_DATA) begin
            rmux = dla ? div_q[7:0] : rxbuf_q;
        end else if (addr_i == A_IEN) begin
            rmux = dla ? div_q[15:8] : ien_q;
        end else if (addr_i == A_IID) begin
            rmux = {5'h00, iid_code};
        end else if (addr_i == A_FMT) begin
            rmux = fmt_q;
        end else if (addr_i == A_LFL) begin
            rmux = lfl;
        end else if (addr_i == A_MFL) begin
            rmux = {~modem_n_i, mdelta_q};
        end else if (addr_i == A_SCR) begin
            rmux = scr_q;
        end else begin
            rmux = 8'h00;
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rdata_q <= 8'h00;
        end else if (ce_i && rd) begin
            rdata_q <= rmux;
        end
    end

    assign rdata_o = rdata_q;
    assign intr_o = intr_q;
    assign serial_out_o = ser_out_q;

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    a_line_first: assert property (int_line |-> iid_code == ID_LINE) else $error("line status not first");
    a_rxd_second: assert property (!int_line && int_rxd |-> iid_code == ID_RXD) else $error("rx data code");
    a_hold_clear: assert property (ce_i && hold_wr |=> !hold_ip_q && !hold_empty_q) else $error("hold kept");
    a_mdm_clear: assert property (ce_i && mfl_rd && mset == 4'h0 |=> mdelta_q == 4'h0)
        else $error("modem flags kept");
    a_idle_code: assert property ((iid_code == ID_NONE) == !int_any) else $error("idle code wrong");
    a_ien_gate: assert property (ce_i && ien_q == 8'h00 |=> !intr_o) else $error("intr unmasked");
    a_stop_len: assert property (tx_st_q == S_STOP |-> tx_cnt_q <= stop_last) else $error("stop too long");
    a_brk_out: assert property (ce_i && fmt_q[FMT_BREAK] |=> !serial_out_o) else $error("break not low");
    a_ready_set: assert property (ce_i && pop |=> rdy_q && rxbuf_q == $past(fifo_q[rp_q]))
        else $error("ready load");
    a_ovr_set: assert property (ce_i && rx_push && f_full |=> oe_q) else $error("overrun missed");
    a_all_empty: assert property (ce_i && lfl_rd |=> rdata_o[6] == $past(hold_empty_q && tx_idle))
        else $error("all empty");
    a_lfl_msb: assert property (ce_i && lfl_rd |=> !rdata_o[7]) else $error("flags bit7 set");
    a_idle_high: assert property (ce_i && tx_idle && !fmt_q[FMT_BREAK] |=> serial_out_o) else $error("idle low");

    c_parity_err: cover property (ce_i && par_set);
    c_break: cover property (ce_i && brk_set);
    c_overrun: cover property (ce_i && rx_push && f_full);
    c_tx_refill: cover property (ce_i && tx_load ##1 hold_wr);

endmodule
`default_nettype wire

// >>> design/ulf_pkg.sv
// constants and states for the serial line format and status core
// assumes the 16x tick is derived inside the core from the system clock
`default_nettype none
package ulf_pkg;
    // register select offsets
    localparam logic [2:0] A_DATA = 3'h0;
    localparam logic [2:0] A_IEN = 3'h1;
    localparam logic [2:0] A_IID = 3'h2;
    localparam logic [2:0] A_FMT = 3'h3;
    localparam logic [2:0] A_MCTL = 3'h4;
    localparam logic [2:0] A_LFL = 3'h5;
    localparam logic [2:0] A_MFL = 3'h6;
    localparam logic [2:0] A_SCR = 3'h7;
    // serial_format_control fields
    localparam int FMT_STOPS = 2;
    localparam int FMT_PAR_EN = 3;
    localparam int FMT_EVEN = 4;
    localparam int FMT_STICK = 5;
    localparam int FMT_BREAK = 6;
    localparam int FMT_DIV = 7;
    // interrupt_enables fields
    localparam int IEN_RXD = 0;
    localparam int IEN_HOLD = 1;
    localparam int IEN_LINE = 2;
    localparam int IEN_MDM = 3;
    // interrupt_source_id codes
    localparam logic [2:0] ID_NONE = 3'h1;
    localparam logic [2:0] ID_LINE = 3'h6;
    localparam logic [2:0] ID_RXD = 3'h4;
    localparam logic [2:0] ID_HOLD = 3'h2;
    localparam logic [2:0] ID_MDM = 3'h0;
    // reset values
    localparam logic [7:0] FMT_RST = 8'h00;
    localparam logic [7:0] IEN_RST = 8'h00;
    localparam logic [15:0] DIV_RST = 16'h0001;
    localparam logic [3:0] MDM_RST = 4'hF;
    // 16x tick timing
    localparam logic [3:0] TICK_MID = 4'h7;
    localparam logic [3:0] TICK_LAST = 4'hF;
    localparam logic [5:0] STOP1_LAST = 6'h0F;
    localparam logic [5:0] STOP15_LAST = 6'h17;
    localparam logic [5:0] STOP2_LAST = 6'h1F;
    // receive buffer depth
    localparam int FIFO_DEPTH = 2;
    localparam logic [1:0] FIFO_FULL = 2'h2;

    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_START = 3'b001,
        S_DATA = 3'b010,
        S_PAR = 3'b011,
        S_STOP = 3'b100,
        S_BRK = 3'b101
    } ulf_state_t;
endpackage
`default_nettype wire

// >>> tb/ulf_peer.sv
// serial peripheral model on the far side of the line core
// assumes a 16x tick every clock, so one bit is 16 clocks
`timescale 1ns/1ps
`default_nettype none
module ulf_peer (
    input wire logic clk_i,
    input wire logic line_i,
    output logic line_o
);
    initial begin
        line_o = 1'b1;
    end
    ////////////////////////////////////////////////////////////
    // send a start bit, then 12 bit slots lsb first
    task automatic send(input logic [11:0] bits);
        int i;
        @(negedge clk_i);
        for (i = 0; i < 13; i++) begin
            line_o = (i == 0) ? 1'b0 : bits[i-1];
            repeat (16) @(negedge clk_i);
        end
        line_o = 1'b1;
    endtask
    ////////////////////////////////////////////////////////////
    // catch one frame, sampling 12 slots at bit centres
    task automatic grab(output bit ok, output logic [11:0] bits);
        int k;
        ok = 1'b0;
        bits = 12'h000;
        for (k = 0; k < 400 && line_i !== 1'b0; k++) begin
            @(negedge clk_i);
        end
        if (line_i === 1'b0) begin
            repeat (8) @(negedge clk_i);
            for (k = 0; k < 12; k++) begin
                repeat (16) @(negedge clk_i);
                bits[k] = line_i;
            end
            ok = 1'b1;
        end
    endtask
endmodule
`default_nettype wire

// >>> tb/tb_ulf_line_core.sv
// register-level testbench of the line format and status core
// assumes divisor reset of one and a peer model on the serial line
`timescale 1ns/1ps
`default_nettype none
module tb_ulf_line_core import ulf_pkg::*; ;
    logic clk_i, sys_rst_i, cs_i, rd_i, wr_i, intr_o, ser_out, sin;
    logic [2:0] addr_i;
    logic [7:0] wdata_i, rdata_o, v;
    logic [3:0] modem_n_i;
    logic [11:0] b, e;
    logic [7:0] fl [5] = '{8'h00, 8'h0D, 8'h1A, 8'h2B, 8'h3B};
    bit ok;
    int miscompares = 0;
    int total_checks = 0;
    int n;
    ulf_line_core dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(1'b1), .cs_i(cs_i),
        .rd_i(rd_i), .wr_i(wr_i), .addr_i(addr_i), .wdata_i(wdata_i), .rdata_o(rdata_o),
        .intr_o(intr_o), .serial_in_i(sin), .serial_out_o(ser_out), .modem_n_i(modem_n_i));
    ulf_peer peer (.clk_i(clk_i), .line_i(ser_out), .line_o(sin));
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    ////////////////////////////////////////////////////////////
    // helpers
    task automatic close_out();
        if (miscompares == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [11:0] seen, input logic [11:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(negedge clk_i);
        {cs_i, wr_i, addr_i, wdata_i} = {2'b11, a, d};
        @(negedge clk_i);
        {cs_i, wr_i} = 2'b00;
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(negedge clk_i);
        {cs_i, rd_i, addr_i} = {2'b11, a};
        @(negedge clk_i);
        {cs_i, rd_i} = 2'b00;
        d = rdata_o;
    endtask
    task automatic rdc(input logic [2:0] a, input logic [7:0] exp, input string nm);
        logic [7:0] d;
        rd(a, d);
        chk(nm, d, exp);
    endtask
    function automatic logic [11:0] frame(input logic [7:0] f, input logic [7:0] d);
        logic [11:0] r;
        logic [7:0] m;
        int n;
        n = 5 + f[1:0];
        m = d & (8'hFF >> (3 - f[1:0]));
        r = 12'hFFF;
        for (int i = 0; i < n; i++) r[i] = m[i];
        if (f[3]) r[n] = f[5] ? ~f[4] : (f[4] ? ^m : ~^m);
        return r;
    endfunction
    task automatic grab_chk(input logic [11:0] exp);
        peer.grab(ok, b);
        if (!ok) begin
            chk("tx start", 12'h0, 12'h1);
            close_out();
        end
        chk("tx frame", b, exp);
    endtask
    ////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        {sys_rst_i, cs_i, rd_i, wr_i, addr_i, wdata_i, modem_n_i} = {4'h8, 3'h0, 8'h00, 4'hF};
        repeat (2) @(negedge clk_i);
        sys_rst_i = 1'b0;
        rdc(A_FMT, 8'h00, "format");
        rdc(A_LFL, 8'h60, "flags");
        rdc(A_IID, 8'h01, "id");
        wr(A_LFL, 8'hFF);
        rdc(A_LFL, 8'h60, "flags ro");
        rdc(A_MCTL, 8'h00, "unmapped");
        for (int i = 0; i < 5; i++) begin
            e = frame(fl[i], 8'hA5 ^ i[7:0]);
            wr(A_FMT, fl[i]);
            wr(A_DATA, 8'hA5 ^ i[7:0]);
            grab_chk(e);
            peer.send(e);
            rdc(A_LFL, 8'h61, "ready");
            rdc(A_IID, 8'h01, "id masked");
            rdc(A_DATA, e[7:0] & (8'hFF >> (3 - fl[i][1:0])), "rx data");
        end
        rdc(A_LFL, 8'h60, "ready clr");
        wr(A_FMT, 8'h1B);
        e = frame(8'h1B, 8'h3C);
        peer.send(e ^ 12'h100);
        rdc(A_LFL, 8'h65, "parity");
        rdc(A_DATA, 8'h3C, "par data");
        rdc(A_LFL, 8'h60, "parity clr");
        peer.send(e & ~12'h200);
        rdc(A_LFL, 8'h69, "framing");
        rdc(A_DATA, 8'h3C, "fe data");
        rdc(A_LFL, 8'h60, "framing clr");
        peer.send(12'h000);
        rd(A_LFL, v);
        chk("break", v & 8'h11, 8'h10);
        rdc(A_LFL, 8'h60, "break clr");
        for (int j = 0; j < 4; j++) peer.send(frame(8'h1B, j[7:0]));
        rdc(A_LFL, 8'h63, "overrun");
        for (int j = 0; j < 3; j++) rdc(A_DATA, j[7:0], "drain");
        rdc(A_LFL, 8'h60, "overrun clr");
        wr(A_IEN, 8'h07);
        peer.send(frame(8'h1B, 8'h5A) ^ 12'h100);
        rdc(A_IID, 8'h06, "id line");
        chk("intr", intr_o, 1'b1);
        rdc(A_LFL, 8'h65, "flags");
        rdc(A_IID, 8'h04, "id rxd");
        rdc(A_DATA, 8'h5A, "rx data");
        rdc(A_IID, 8'h02, "id tx_holding_empty");
        rdc(A_IID, 8'h01, "id none");
        @(negedge clk_i);
        chk("intr", intr_o, 1'b0);
        wr(A_IEN, 8'h08);
        modem_n_i = 4'hE;
        rdc(A_IID, 8'h00, "id modem");
        rdc(A_MFL, 8'h11, "modem");
        rdc(A_IID, 8'h01, "id modem clr");
        wr(A_FMT, 8'h43);
        wr(A_DATA, 8'h00);
        repeat (40) @(negedge clk_i);
        chk("break out", ser_out, 1'b0);
        rdc(A_LFL, 8'h20, "tx runs");
        wr(A_FMT, 8'h03);
        repeat (120) @(negedge clk_i);
        chk("idle out", ser_out, 1'b1);
        wr(A_FMT, 8'h04);
        wr(A_DATA, 8'h00);
        wr(A_DATA, 8'h00);
        for (n = 0; n < 300 && ser_out !== 1'b1; n++) @(negedge clk_i);
        for (n = 0; n < 300 && ser_out === 1'b1; n++) @(negedge clk_i);
        chk("stop span", n[11:0], 12'h019);
        wr(A_FMT, 8'h83);
        wr(A_DATA, 8'h01);
        wr(A_IEN, 8'h00);
        rdc(A_DATA, 8'h01, "div low");
        rdc(A_IEN, 8'h00, "div high");
        wr(A_FMT, 8'h03);
        rdc(A_IEN, 8'h08, "enables");
        close_out();
    end
endmodule
`default_nettype wire
